// ---- core/formatter_pkg.sv ----
// constants, types and carriers shared by the data dump formatter
// Functional notes
// - temperature channels spread over eight frames
// - second mux sampled each frame, carries temperature
// - 12-bit conversions stored in housekeeping buffer
// - conversions start only on mux enable
// - buffered words read out without gaps
// - digital mux scanned during dump
// - dump opens with fixed sync pattern
// - then time code and status bits
// - deserialize time code, refresh on completion
// - latch time code at dwell start
// - never latch time code mid-update
// - select digital mux, housekeeping or accumulator
// - source switches only at bit boundaries
// - source read strobes aligned to bit clock
// - end-of-accumulation strobe to signal processor
// - data valid rises before first bit
// - device supplies clock, spacecraft samples with it
// - data valid falls after last bit
// - pulled interface needs buffering and filler bits
// - divide orbit into equal latitude increments
// - 38 cycles of 16.508 ms, 5.008 ms pulse
// - two noise-only cycles per dwell
// - accumulator words truncated to 16 bits
package formatter_pkg;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int CYCLE_TIME_NS    = 16508000;
  localparam int PULSE_MAX_NS     = 5008000;
  // cycle time and pulse limit both divide exactly by the clock period
  localparam int CYCLE_CLKS       = CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int PULSE_CLKS       = PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int CYCLES_PER_DWELL = 38;
  localparam int NOISE_CYCLES     = 2;
  localparam int TEMP_FRAMES      = 8;
  localparam int HK_CHANS         = 8;
  localparam int SETTLE_CLKS      = 16;
  localparam int BIT_HALF_CLKS    = 4;
  localparam int SP_WORDS         = 25;
  localparam int FIFO_DEPTH       = 16;
  localparam int LAT_INCREMENTS   = 128;
  localparam int LAT_BITS         = 8;
  localparam int TC_BITS          = 32;
  localparam int STATUS_BITS      = 16;
  localparam int ADC_BITS         = 12;
  localparam int SP_IN_BITS       = 20;
  localparam int SP_OUT_BITS      = 16;
  localparam int SYNC_BITS        = 32;
  localparam logic [31:0] SYNC_PATTERN = 32'hfe6b_2840;

  // dump sections in transmission order
  typedef enum logic [2:0] {
    SEC_SYNC = 3'h0,
    SEC_TC   = 3'h1,
    SEC_STAT = 3'h2,
    SEC_HK   = 3'h3,
    SEC_SP   = 3'h4,
    SEC_DONE = 3'h5
  } section_e;

  // serial link toward the spacecraft
  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic data_valid;
  } link_out_s;

  // serial time code from the spacecraft
  typedef struct packed {
    logic clk;
    logic data;
    logic gate;
  } tc_link_s;

  // transmit/receive timing outputs
  typedef struct packed {
    logic transmit;
    logic noise_only;
    logic end_accum;
  } timing_s;
endpackage

// ---- core/word_fifo.sv ----
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two so pointers wrap naturally
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
    logic                    in_ready;
    logic                    out_valid;
  } state_s;

  state_s r;
  state_s next_r;

  assign in_ready  = r.in_ready;
  assign out_valid = r.out_valid;
  assign out_data  = r.mem[r.rd];

  ////////////////////////////////////////////////////////////////////////////
  // push and pop; flags registered from the next count
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    next_r = r;
    push = in_valid & r.in_ready;
    pop = out_ready & r.out_valid;
    if (push) begin
      next_r.mem[r.wr] = in_data;
      next_r.wr = r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = r.rd + 1'b1;
    end
    if (push & ~pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop & ~push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    // full stalls the source, empty stalls the drain
    next_r.in_ready = (next_r.cnt != (AW+1)'(DEPTH));
    next_r.out_valid = (next_r.cnt != '0);
  end

  // register the whole state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ---- core/dump_formatter.sv ----
// housekeeping collector, time code latch, timing and serial dump
`timescale 1ns/1ps
module dump_formatter #(
  parameter int CYCLE_CLKS = formatter_pkg::CYCLE_CLKS,
  parameter int PULSE_CLKS = formatter_pkg::PULSE_CLKS,
  parameter int HK_CHANS   = formatter_pkg::HK_CHANS,
  parameter int SP_WORDS   = formatter_pkg::SP_WORDS,
  parameter int BIT_HALF   = formatter_pkg::BIT_HALF_CLKS,
  parameter int SETTLE     = formatter_pkg::SETTLE_CLKS,
  parameter int LAT_INC    = formatter_pkg::LAT_INCREMENTS,
  parameter int FIFO_DEPTH = formatter_pkg::FIFO_DEPTH
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire formatter_pkg::tc_link_s tc_link,
  input  wire logic                  orbit_marker,
  input  wire logic                  mux_enable,
  input  wire logic [15:0]           status_in,
  input  wire logic [11:0]           adc_data,
  input  wire logic                  adc_done,
  input  wire logic                  sp_valid,
  input  wire logic [19:0]           sp_word,
  output logic                       sp_ready,
  output logic                       adc_start,
  output logic [$clog2(HK_CHANS)-1:0] analog_sel,
  output logic [2:0]                 temp_sel,
  output logic [7:0]                 latitude,
  output formatter_pkg::timing_s     timing,
  output formatter_pkg::link_out_s   link
);
  localparam int CW = $clog2(HK_CHANS);

  typedef enum logic [1:0] {
    H_IDLE   = 2'h0,
    H_SETTLE = 2'h1,
    H_CONV   = 2'h2
  } hk_e;

  typedef enum logic [1:0] {
    D_IDLE = 2'h0,
    D_LEAD = 2'h1,
    D_SEND = 2'h2
  } dump_e;

  typedef struct packed {
    formatter_pkg::tc_link_s tc_s1;     // first sync stage only
    formatter_pkg::tc_link_s tc_s2;
    formatter_pkg::tc_link_s tc_prev;   // for edge detection
    logic [31:0]             tc_shift;  // incoming serial code
    logic [5:0]              tc_cnt;
    logic [31:0]             tc_par;    // reformatted parallel code
    logic                    tc_upd;
    logic [31:0]             tc_latch;  // held code sent in dump
    logic                    tc_pend;
    logic                    om_s1;
    logic                    om_s2;
    logic                    om_prev;
    logic                    om_seen;   // a first marker has passed
    logic [47:0]             lat_period;
    logic [47:0]             lat_cnt;
    logic [47:0]             lat_acc;
    logic [7:0]              latitude;
    logic [31:0]             cyc_clk;
    logic [5:0]              dwell_idx;
    formatter_pkg::timing_s  timing;
    hk_e                     hst;
    logic [CW-1:0]           ch;
    logic [2:0]              frame;
    logic [15:0]             settle;
    logic                    adc_start;
    logic                    men_prev;
    logic [HK_CHANS-1:0][11:0] hk_mem;
    dump_e                   dst;
    formatter_pkg::section_e sec;
    logic [4:0]              word;
    logic [5:0]              bit_left;
    logic [31:0]             shreg;
    logic [15:0]             div;
    logic [15:0]             status_snap;
    formatter_pkg::link_out_s link;
  } state_s;

  state_s      r;
  state_s      next_r;
  logic        pop;        // accumulator read strobe
  logic        fifo_valid;
  logic [19:0] fifo_data;

  ////////////////////////////////////////////////////////////////////////////
  // accumulator words queue here so the processor can run ahead
  word_fifo #(
    .W     (formatter_pkg::SP_IN_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (sp_valid),
    .in_ready  (sp_ready),
    .in_data   (sp_word),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // words in each dump section
  function automatic logic [4:0] sec_words(formatter_pkg::section_e s);
    unique case (s)
      formatter_pkg::SEC_HK: sec_words = 5'(HK_CHANS);
      formatter_pkg::SEC_SP: sec_words = 5'(SP_WORDS);
      default:               sec_words = 5'h1;
    endcase
  endfunction

  // bits per word in each dump section
  function automatic logic [5:0] sec_width(formatter_pkg::section_e s);
    unique case (s)
      formatter_pkg::SEC_SYNC: sec_width = 6'(formatter_pkg::SYNC_BITS);
      formatter_pkg::SEC_TC:   sec_width = 6'(formatter_pkg::TC_BITS);
      formatter_pkg::SEC_STAT: sec_width = 6'(formatter_pkg::STATUS_BITS);
      formatter_pkg::SEC_HK:   sec_width = 6'(formatter_pkg::ADC_BITS);
      formatter_pkg::SEC_SP:   sec_width = 6'(formatter_pkg::SP_OUT_BITS);
      default:                 sec_width = 6'h1;
    endcase
  endfunction

  assign adc_start  = r.adc_start;
  assign analog_sel = r.ch;
  assign temp_sel   = r.frame;
  assign latitude   = r.latitude;
  assign timing     = r.timing;
  assign link       = r.link;

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    logic        dwell_end;
    logic        tc_rise;
    logic        tc_gate_fall;
    logic        bnd;
    logic [31:0] w;
    dwell_end = 1'b0;
    tc_rise = 1'b0;
    tc_gate_fall = 1'b0;
    bnd = 1'b0;
    w = '0;
    next_r = r;
    pop = 1'b0;
    next_r.timing.end_accum = 1'b0;
    next_r.adc_start = 1'b0;
    next_r.tc_upd = 1'b0;

    // time code pins pass two stages before any logic looks at them
    next_r.tc_s1 = tc_link;
    next_r.tc_s2 = r.tc_s1;
    next_r.tc_prev = r.tc_s2;
    tc_rise = r.tc_s2.clk & ~r.tc_prev.clk;
    tc_gate_fall = r.tc_prev.gate & ~r.tc_s2.gate;
    if (r.tc_s2.gate & ~r.tc_prev.gate) begin
      next_r.tc_cnt = '0;
    end else if (tc_rise & r.tc_s2.gate) begin
      next_r.tc_shift = {r.tc_shift[30:0], r.tc_s2.data};
      next_r.tc_cnt = r.tc_cnt + 6'h1;
    end
    // short codes are discarded, parallel word keeps last good one
    if (tc_gate_fall && r.tc_cnt == 6'(formatter_pkg::TC_BITS)) begin
      next_r.tc_par = r.tc_shift;
      next_r.tc_upd = 1'b1;
    end

    // transmit/receive cycle and dwell counting
    if (r.cyc_clk == 32'(CYCLE_CLKS - 1)) begin
      next_r.cyc_clk = '0;
      if (r.dwell_idx == 6'(formatter_pkg::CYCLES_PER_DWELL - 1)) begin
        next_r.dwell_idx = '0;
        dwell_end = 1'b1;
      end else begin
        next_r.dwell_idx = r.dwell_idx + 6'h1;
      end
    end else begin
      next_r.cyc_clk = r.cyc_clk + 32'h1;
    end
    // last cycles of each dwell carry no pulse: noise only
    next_r.timing.noise_only = (next_r.dwell_idx >=
      6'(formatter_pkg::CYCLES_PER_DWELL - formatter_pkg::NOISE_CYCLES));
    // current count, not next: the first pulse after reset is full length
    next_r.timing.transmit = ~next_r.timing.noise_only &&
      (r.cyc_clk < 32'(PULSE_CLKS));
    next_r.timing.end_accum = dwell_end;

    // capture at dwell start; wait while a code is arriving or landing
    if (dwell_end | r.tc_pend) begin
      if (r.tc_s2.gate | r.tc_upd | next_r.tc_upd) begin
        next_r.tc_pend = 1'b1;
      end else begin
        next_r.tc_latch = r.tc_par;
        next_r.tc_pend = 1'b0;
      end
    end

    // orbit marker: measure the last orbit, step latitude by fractions
    next_r.om_s1 = orbit_marker;
    next_r.om_s2 = r.om_s1;
    next_r.om_prev = r.om_s2;
    if (r.om_s2 & ~r.om_prev) begin
      // reset to first marker is no orbit; keep output at zero until then
      if (r.om_seen) begin
        next_r.lat_period = r.lat_cnt + 48'h1;
      end
      next_r.om_seen = 1'b1;
      next_r.lat_cnt = '0;
      next_r.lat_acc = '0;
      next_r.latitude = '0;
    end else begin
      next_r.lat_cnt = r.lat_cnt + 48'h1;
      // running remainder avoids a hardware divider
      if (r.lat_period != '0) begin
        next_r.lat_acc = r.lat_acc + 48'(LAT_INC);
        if (next_r.lat_acc >= r.lat_period) begin
          next_r.lat_acc = next_r.lat_acc - r.lat_period;
          if (r.latitude != 8'(LAT_INC - 1)) begin
            next_r.latitude = r.latitude + 8'h1;
          end
        end
      end
    end

    // analog housekeeping sequencing
    next_r.men_prev = mux_enable;
    unique case (r.hst)
      H_IDLE: begin
        if (mux_enable & ~r.men_prev) begin
          next_r.hst = H_SETTLE;
          next_r.ch = '0;
          next_r.settle = '0;
        end
      end
      H_SETTLE: begin
        // mux outputs need time before a conversion is started
        if (r.settle == 16'(SETTLE - 1)) begin
          next_r.adc_start = 1'b1;
          next_r.hst = H_CONV;
        end else begin
          next_r.settle = r.settle + 16'h1;
        end
      end
      H_CONV: begin
        if (adc_done) begin
          next_r.hk_mem[r.ch] = adc_data;
          if (r.ch == CW'(HK_CHANS - 1)) begin
            // one temperature input per frame, eight frames per set
            next_r.frame = r.frame + 3'h1;
            next_r.hst = H_IDLE;
          end else begin
            next_r.ch = r.ch + 1'b1;
            next_r.settle = '0;
            next_r.hst = H_SETTLE;
          end
        end
      end
      default: begin
        next_r.hst = H_IDLE;
      end
    endcase

    // serial dump: bit clock low at boundaries, high at mid bit
    bnd = (r.div == 16'(2 * BIT_HALF - 1));
    if (r.dst != D_IDLE) begin
      next_r.div = bnd ? 16'h0 : r.div + 16'h1;
    end
    unique case (r.dst)
      D_IDLE: begin
        // a dwell end during a dump is skipped, accumulators ping-pong
        if (dwell_end) begin
          next_r.dst = D_LEAD;
          next_r.link.data_valid = 1'b1;
          next_r.div = '0;
          next_r.sec = formatter_pkg::SEC_SYNC;
          next_r.word = '0;
          next_r.bit_left = '0;
          next_r.status_snap = status_in;
        end
      end
      D_LEAD: begin
        // one idle bit time with valid high before the first bit
        if (bnd) begin
          next_r.dst = D_SEND;
        end
      end
      D_SEND: begin
        if (r.div == 16'(BIT_HALF - 1)) begin
          next_r.link.ser_clk = 1'b1;
        end
        if (bnd) begin
          next_r.link.ser_clk = 1'b0;
        end
      end
      default: begin
        next_r.dst = D_IDLE;
      end
    endcase

    // every source change and read strobe falls on a bit boundary
    if (bnd && r.dst != D_IDLE) begin
      if (r.dst == D_SEND && r.bit_left != '0) begin
        next_r.shreg = {r.shreg[30:0], 1'b0};
        next_r.link.ser_data = r.shreg[30];
        next_r.bit_left = r.bit_left - 6'h1;
      end else if (r.sec == formatter_pkg::SEC_DONE) begin
        next_r.dst = D_IDLE;
        next_r.link.data_valid = 1'b0;
        next_r.link.ser_data = 1'b0;
      end else begin
        unique case (r.sec)
          formatter_pkg::SEC_SYNC: w = formatter_pkg::SYNC_PATTERN;
          formatter_pkg::SEC_TC:   w = r.tc_latch;
          formatter_pkg::SEC_STAT: w = {r.status_snap, 16'h0};
          formatter_pkg::SEC_HK:   w = {r.hk_mem[r.word[CW-1:0]], 20'h0};
          formatter_pkg::SEC_SP: begin
            // keep the upper bits; empty queue sends zero filler
            pop = fifo_valid;
            w = fifo_valid ? {fifo_data[19:4], 16'h0} : 32'h0;
          end
          default: w = 32'h0;
        endcase
        next_r.shreg = w;
        next_r.link.ser_data = w[31];
        next_r.bit_left = sec_width(r.sec) - 6'h1;
        if (r.word == sec_words(r.sec) - 5'h1) begin
          next_r.word = '0;
          next_r.sec = formatter_pkg::section_e'(r.sec + 3'h1);
        end else begin
          next_r.word = r.word + 5'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single register for the whole state; reset idles the link
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ---- verif/formatter_checker_assertions.sv ----
// port-level checks on the dump formatter
`timescale 1ns/1ps
module formatter_checker #(
  parameter int CYCLE_CLKS = 200,
  parameter int PULSE_CLKS = 60,
  parameter int HK_CHANS   = 8
) (
  input wire logic                        ref_clk,
  input wire logic                        nrst,
  input wire logic                        adc_start,
  input wire logic [$clog2(HK_CHANS)-1:0] analog_sel,
  input wire formatter_pkg::timing_s      timing,
  input wire formatter_pkg::link_out_s    link
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  // counters: pulse and dwell lengths are far too long to unroll
  int   tx_len;   // cycles transmit has been high
  int   acc_gap;  // cycles since the last dwell end
  logic acc_seen; // a first dwell end has passed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_len   <= 0;
      acc_gap  <= 0;
      acc_seen <= 1'b0;
    end else begin
      tx_len  <= timing.transmit ? tx_len + 1 : 0;
      acc_gap <= timing.end_accum ? 0 : acc_gap + 1;
      if (timing.end_accum) begin
        acc_seen <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // one full bit period of idle clock once the envelope opens
  sequence s_lead;
    (link.data_valid && !link.ser_clk) [*8];
  endsequence
  // high half of a bit, then the clock drops
  sequence s_bit;
    link.ser_clk [*4] ##1 !link.ser_clk;
  endsequence
  a_noise_no_tx: assert property (
    timing.noise_only |-> !timing.transmit)
    else $error("transmit during a noise-only cycle");
  a_tx_width: assert property (
    $fell(timing.transmit) |-> tx_len == PULSE_CLKS)
    else $error("transmit pulse length wrong");
  a_dwell_period: assert property (
    timing.end_accum && acc_seen |->
      acc_gap == formatter_pkg::CYCLES_PER_DWELL * CYCLE_CLKS - 1)
    else $error("dwell end spacing wrong");
  a_accum_single: assert property (
    timing.end_accum |=> !timing.end_accum)
    else $error("end of accumulation longer than one cycle");
  a_noise_at_end: assert property (
    timing.end_accum |-> timing.noise_only || $past(timing.noise_only))
    else $error("noise cycles not at the end of the dwell");
  a_valid_on_accum: assert property (
    $rose(link.data_valid) |-> timing.end_accum)
    else $error("dump opened away from a dwell end");
  a_lead_idle: assert property (
    $rose(link.data_valid) |-> s_lead)
    else $error("no idle bit period ahead of the first bit");
  a_bit_clock: assert property (
    $rose(link.ser_clk) |-> s_bit)
    else $error("serial clock high half wrong");
  a_data_edge: assert property (
    $changed(link.ser_data) |-> !link.ser_clk)
    else $error("serial data moved while clock high");
  a_idle_quiet: assert property (
    !link.data_valid |-> !link.ser_clk && !link.ser_data)
    else $error("link active outside the envelope");
  a_adc_settle: assert property (
    adc_start |-> analog_sel == $past(analog_sel, 8) && !$past(adc_start))
    else $error("conversion started before the mux settled");
endmodule
bind dump_formatter formatter_checker #(
  .CYCLE_CLKS(CYCLE_CLKS),
  .PULSE_CLKS(PULSE_CLKS),
  .HK_CHANS  (HK_CHANS)
) u_chk (
  .ref_clk   (ref_clk),
  .nrst      (nrst),
  .adc_start (adc_start),
  .analog_sel(analog_sel),
  .timing    (timing),
  .link      (link)
);

// ---- verif/spacecraft_model.sv ----
// spacecraft side: time code sender and serial dump receiver
`timescale 1ns/1ps
module spacecraft_model (
  input  wire logic               ser_clk,
  input  wire logic               ser_data,
  input  wire logic               data_valid,
  output formatter_pkg::tc_link_s tc
);
  logic rx_q[$]; // bits captured during dumps
  initial begin
    tc = '0;
  end
  // capture on the supplied clock, only inside the envelope
  always @(posedge ser_clk) begin
    if (data_valid) begin
      rx_q.push_back(ser_data);
    end
  end
  // shift msb first at 64 ns; clock stands still low between codes
  task automatic send_code(input logic [31:0] code, input int n);
    #1.3;
    tc.gate = 1'b1;
    #32;
    for (int b = n - 1; b >= 0; b--) begin
      tc.data = code[b];
      #32;
      tc.clk = 1'b1;
      #32;
      tc.clk = 1'b0;
    end
    #32;
    tc.gate = 1'b0;
    // a released line must not keep showing the last bit
    tc.data = ~tc.data;
  endtask
endmodule

// ---- verif/instrument_data_dump_formatter_tb.sv ----
// self-checking bench for the data dump formatter
`timescale 1ns/1ps
module instrument_data_dump_formatter_tb;
  localparam int          SPW     = 4;   // accumulator words per dump
  localparam logic [31:0] TC_CODE = 32'h3c5a_96e1;
  localparam logic [15:0] STATUS  = 16'hc3a5;
  logic                      ref_clk, nrst, orbit_marker, mux_enable;
  logic [15:0]               status_in;
  logic [11:0]               adc_data;
  logic                      adc_done, sp_valid, sp_ready, adc_start;
  logic [19:0]               sp_word;
  logic [2:0]                analog_sel, temp_sel;
  logic [7:0]                latitude;
  formatter_pkg::timing_s    timing;
  formatter_pkg::link_out_s  link;
  formatter_pkg::tc_link_s   tc_link;
  int                        n_errors, check_count;
  logic                      exp_q[$]; // expected dump bits
  dump_formatter #(.CYCLE_CLKS(200), .PULSE_CLKS(60), .SP_WORDS(SPW)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .tc_link(tc_link),
    .orbit_marker(orbit_marker), .mux_enable(mux_enable),
    .status_in(status_in), .adc_data(adc_data), .adc_done(adc_done),
    .sp_valid(sp_valid), .sp_word(sp_word), .sp_ready(sp_ready),
    .adc_start(adc_start), .analog_sel(analog_sel), .temp_sel(temp_sel),
    .latitude(latitude), .timing(timing), .link(link));
  spacecraft_model u_sc (.ser_clk(link.ser_clk), .ser_data(link.ser_data),
    .data_valid(link.data_valid), .tc(tc_link));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // converter stand-in: answers one cycle later with a channel-coded word
  always @(posedge ref_clk) begin
    adc_done <= adc_start;
    adc_data <= {analog_sel, 9'h0a5};
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // bounded wait on the envelope; running out ends the run
  task automatic wait_valid(input logic lvl);
    for (int i = 0; i < 20000 && link.data_valid !== lvl; i++) begin
      @(negedge ref_clk);
    end
    if (link.data_valid !== lvl) begin
      chk(1'b0, "data valid wait timed out");
      test_done();
    end
  endtask
  function automatic logic [19:0] sp_val(input int i);
    return {8'h5a, 4'(i), 4'h3, 4'hc}; // low nibble must be dropped
  endfunction
  task automatic add(input logic [31:0] v, input int n);
    for (int b = n - 1; b >= 0; b--) exp_q.push_back(v[b]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge ref_clk);
    chk(link === '0 && timing === '0, "outputs busy after reset");
    repeat (2) @(negedge ref_clk);
    chk(sp_ready === 1'b1 && adc_start === 1'b0, "idle state wrong");
    $display("test reset done");
  endtask
  // two passes: eight conversions each, temperature input steps per pass
  task automatic t_house();
    int n;
    for (int p = 1; p <= 2; p++) begin
      @(posedge ref_clk);
      mux_enable <= 1'b1;
      n = 0;
      for (int i = 0; i < 1000 && temp_sel !== 3'(p); i++) begin
        @(negedge ref_clk);
        if (adc_start === 1'b1) n++;
      end
      chk(temp_sel === 3'(p) && n == 8, "housekeeping pass wrong");
      if (temp_sel !== 3'(p)) test_done();
      @(posedge ref_clk);
      mux_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    $display("test housekeeping done");
  endtask
  // fill the buffer until it refuses
  task automatic t_fifo();
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      sp_valid <= 1'b1;
      sp_word  <= sp_val(i);
      @(negedge ref_clk);
      chk(sp_ready === 1'b1, "buffer refused early");
    end
    @(posedge ref_clk);
    sp_valid <= 1'b0;
    @(negedge ref_clk);
    chk(sp_ready === 1'b0, "buffer not full after 16 words");
    $display("test buffer fill done");
  endtask
  task automatic marker();
    @(posedge ref_clk);
    orbit_marker <= 1'b1;
    repeat (4) @(posedge ref_clk);
    orbit_marker <= 1'b0;
  endtask
  // 1280-cycle orbit: one increment per 10 cycles once measured
  task automatic t_lat();
    marker();
    repeat (1275) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(latitude === 8'h00, "latitude moved in first orbit");
    marker();
    repeat (635) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(latitude inside {[8'h3c:8'h44]}, "latitude off");
    $display("test latitude done");
  endtask
  // one dump; buffer holds four dumps' worth, then zero filler
  task automatic t_dump(input int k);
    logic [19:0] w;
    logic        bad;
    exp_q = {};
    add(formatter_pkg::SYNC_PATTERN, 32);
    add(TC_CODE, 32);
    add({16'h0, STATUS}, 16);
    for (int c = 0; c < 8; c++) add({20'h0, 3'(c), 9'h0a5}, 12);
    for (int j = 0; j < SPW; j++) begin
      w = (k < 4) ? sp_val(4 * k + j) : 20'h0;
      add({16'h0, w[19:4]}, 16);
    end
    wait_valid(1'b1);
    @(posedge ref_clk);
    status_in <= ~STATUS; // snapshot from dump start must not follow
    wait_valid(1'b0);
    bad = (u_sc.rx_q.size() != exp_q.size());
    chk(!bad, "dump length wrong");
    foreach (exp_q[i]) if (!bad && u_sc.rx_q[i] !== exp_q[i]) bad = 1'b1;
    chk(!bad, $sformatf("dump %0d content wrong", k));
    u_sc.rx_q = {};
    @(posedge ref_clk);
    status_in <= STATUS;
    $display("test dump %0d done", k);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    nrst         = 1'b0;
    orbit_marker = 1'b0;
    mux_enable   = 1'b0;
    status_in    = STATUS;
    sp_valid     = 1'b0;
    sp_word      = 20'h00000;
    n_errors     = 0;
    check_count  = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    u_sc.send_code(32'h000a_bcde, 20); // short code must be dropped
    u_sc.send_code(TC_CODE, 32);
    t_house();
    t_fifo();
    t_lat();
    for (int k = 0; k < 5; k++) t_dump(k);
    test_done();
  end
endmodule
